// File: acc_ctrl.sv
// Converter control: AHB-Lite registers, clocking, sequencing, results
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module acc_ctrl
   import acc_pkg::*;
#(
   parameter int RES_W = 10
) (
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   input  wire logic              hsel_in,
   input  wire logic [31:0]       haddr_in,
   input  wire logic [1:0]        htrans_in,
   input  wire logic              hwrite_in,
   input  wire logic [2:0]        hsize_in,
   input  wire logic [31:0]       hwdata_in,
   input  wire logic              hready_in,
   output logic      [31:0]       hrdata_out,
   output logic                   hreadyout_out,
   output logic                   hresp_out,
   input  wire logic [4:0]        trig_src_in,
   input  wire logic              sleep_in,
   input  wire logic              comp_in,
   output acc_analog_t            analog_out,
   output logic [RES_W-1:0]       trial_out,
   output logic                   wake_out,
   output logic                   vector_out
);

   ////////////////////////////////////////////////////////////////////////
   // Bus address phase capture
   logic        wr_q;
   logic        rd_q;
   logic [7:0]  addr_q;
   wire  logic  take = hsel_in & hready_in & htrans_in[1];

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         addr_q <= 8'h00;
      end else begin
         wr_q   <= take & hwrite_in;
         rd_q   <= take & ~hwrite_in;
         addr_q <= haddr_in[7:0];
      end
   end

   // Zero wait states, always OKAY
   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;

   // Write decode
   wire logic [7:0] wb   = hwdata_in[7:0];
   wire logic wr_c0      = wr_q && addr_q == ACC_OFS_CTRL0;
   wire logic wr_c1      = wr_q && addr_q == ACC_OFS_CTRL1;
   wire logic wr_c2      = wr_q && addr_q == ACC_OFS_CTRL2;
   wire logic wr_irq     = wr_q && addr_q == ACC_OFS_IRQ;

   ////////////////////////////////////////////////////////////////////////
   // Control registers
   logic        on_q;
   logic [4:0]  chs_q;
   logic        fm_q;
   logic [2:0]  cs_q;
   logic [1:0]  pref_q;
   logic [3:0]  trg_q;
   logic        ie_q;
   logic        pe_q;
   logic        ge_q;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         on_q   <= 1'b0;
         chs_q  <= 5'h00;
         fm_q   <= 1'b0;
         cs_q   <= 3'h0;
         pref_q <= 2'h0;
         trg_q  <= 4'h0;
         ie_q   <= 1'b0;
         pe_q   <= 1'b0;
         ge_q   <= 1'b0;
      end else begin
         if (wr_c0) begin
            on_q  <= wb[ACC_C0_ON];
            chs_q <= wb[ACC_C0_CHS +: 5];
         end
         if (wr_c1) begin
            fm_q   <= wb[ACC_C1_FM];
            cs_q   <= wb[ACC_C1_CS +: 3];
            pref_q <= wb[ACC_C1_PREF +: 2];
         end
         if (wr_c2) begin
            trg_q <= wb[ACC_C2_TRIG +: 4];
         end
         if (wr_irq) begin
            ie_q <= wb[ACC_IRQ_IE];
            pe_q <= wb[ACC_IRQ_PE];
            ge_q <= wb[ACC_IRQ_GE];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers for triggers, sleep and comparator
   logic [6:0] meta_q;
   logic [6:0] sync_q;
   logic [4:0] trg_prev_q;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_q     <= 7'h00;
         sync_q     <= 7'h00;
         trg_prev_q <= 5'h00;
      end else begin
         meta_q     <= {comp_in, sleep_in, trig_src_in};
         sync_q     <= meta_q;
         trg_prev_q <= sync_q[4:0];
      end
   end

   wire logic [4:0] trg_rise = sync_q[4:0] & ~trg_prev_q;
   wire logic       asleep   = sync_q[5];
   wire logic       comp     = sync_q[6];
   // Reserved codes above five never fire
   wire logic trg_hit = (trg_q != 4'h0) && (trg_q <= ACC_TRG_MAX)
                        && trg_rise[3'(trg_q - 4'h1)];

   ////////////////////////////////////////////////////////////////////////
   // Conversion clock: half-period tick pulses
   wire logic rc_sel = cs_q[1:0] == 2'b11;
   logic [7:0] half_cyc;
   always_comb begin
      case (cs_q)
         3'b000:  half_cyc = 8'h01;
         3'b100:  half_cyc = 8'h02;
         3'b001:  half_cyc = 8'h04;
         3'b101:  half_cyc = 8'h08;
         3'b010:  half_cyc = 8'h10;
         3'b110:  half_cyc = 8'h20;
         default: half_cyc = ACC_RC_HALF_CYC;
      endcase
   end

   logic [7:0] div_q;
   wire  logic tick = div_q >= half_cyc - 8'h01;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   acc_state_t st_q;
   logic       go_q;
   logic       flag_q;
   logic       pwr_dn_q;
   logic [4:0] step_q;
   logic [7:0] dly_q;
   logic [RES_W-1:0] sar_q;
   logic [RES_W-1:0] bit_q;
   logic [RES_W-1:0] res_q;

   wire logic conv  = st_q != ACC_IDLE;
   // Software go write, only when already enabled
   wire logic sw_go = wr_c0 && wb[ACC_C0_GO] && on_q;
   wire logic sw_ab = wr_c0 && !wb[ACC_C0_GO] && conv;
   wire logic start = !conv && on_q && !pwr_dn_q && (sw_go || trg_hit);
   // Sleep kills conversions unless running on the RC clock
   wire logic sleep_ab = conv && asleep && !rc_sel;
   wire logic last     = st_q == ACC_CONV && tick && step_q == ACC_HALF_STEPS - 5'h01;
   wire logic resolve  = st_q == ACC_CONV && tick && step_q[0] && step_q <= 5'h13;
   wire logic abort    = sw_ab || sleep_ab || (conv && !on_q);

   // Resolved mask grows from the MSB down; the newly added bit is on trial
   wire logic [RES_W-1:0] mask_nx = (bit_q >> 1) | {1'b1, {(RES_W - 1){1'b0}}};
   wire logic [RES_W-1:0] trial   = mask_nx & ~bit_q;

   // Abort fill: unresolved bits copy the last resolved one
   logic [RES_W-1:0] part;
   always_comb begin
      part = sar_q;
      for (int i = RES_W - 2; i >= 0; i--) begin
         if (!bit_q[i]) begin
            part[i] = part[i + 1];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || st_q == ACC_IDLE) begin
         div_q <= 8'h00;
      end else if (tick) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_q     <= ACC_IDLE;
         go_q     <= 1'b0;
         step_q   <= 5'h00;
         dly_q    <= 8'h00;
         sar_q    <= '0;
         bit_q    <= '0;
         res_q    <= '0;
         pwr_dn_q <= 1'b0;
      end else begin
         if (!asleep || !on_q) begin
            pwr_dn_q <= 1'b0;
         end
         case (st_q)
            ACC_IDLE: begin
               if (start) begin
                  go_q  <= 1'b1;
                  st_q  <= rc_sel ? ACC_DELAY : ACC_CONV;
                  dly_q <= ACC_INSTR_CYC;
                  step_q <= 5'h00;
                  sar_q <= '0;
                  bit_q <= '0;
               end
            end
            ACC_DELAY: begin
               dly_q <= dly_q - 8'h01;
               if (dly_q == 8'h01) begin
                  st_q <= ACC_CONV;
               end
            end
            default: begin
               if (tick) begin
                  step_q <= step_q + 5'h01;
               end
               if (resolve) begin
                  sar_q <= sar_q | (comp ? trial : '0);
                  bit_q <= mask_nx;
               end
            end
         endcase
         if (conv && (last || abort)) begin
            st_q  <= ACC_IDLE;
            go_q  <= 1'b0;
            res_q <= last ? sar_q : part;
         end
         if (conv && sleep_ab) begin
            pwr_dn_q <= 1'b1;
         end
         if (last && asleep && !ie_q) begin
            pwr_dn_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Done flag: hardware set wins over software clear
   wire logic flag_clr = wr_irq && !wb[ACC_IRQ_FLG];
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         flag_q <= 1'b0;
      end else if (last) begin
         flag_q <= 1'b1;
      end else if (flag_clr) begin
         flag_q <= 1'b0;
      end
   end

   // Wake and vector requests
   logic wake_q;
   logic vec_q;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wake_q <= 1'b0;
         vec_q  <= 1'b0;
      end else begin
         wake_q <= asleep && flag_q && ie_q;
         vec_q  <= flag_q && ie_q && pe_q && ge_q;
      end
   end
   assign wake_out   = wake_q;
   assign vector_out = vec_q;

   ////////////////////////////////////////////////////////////////////////
   // Justified result bytes
   wire logic [7:0] res_hi = fm_q ? {6'h00, res_q[9:8]} : res_q[9:2];
   wire logic [7:0] res_lo = fm_q ? res_q[7:0] : {res_q[1:0], 6'h00};

   // Read mux, selected by the address registered at address phase
   wire logic [7:0] rd_c0  = {1'b0, chs_q, go_q, on_q};
   wire logic [7:0] rd_c1  = {fm_q, cs_q, 2'b00, pref_q};
   wire logic [7:0] rd_c2  = {trg_q, 4'h0};
   wire logic [7:0] rd_irq = {4'h0, ge_q, pe_q, ie_q, flag_q};
   wire logic [7:0] rd_st  = {5'h00, pwr_dn_q, st_q};
   wire logic [7:0] rd_sel =
        (addr_q == ACC_OFS_CTRL0) ? rd_c0 :
        (addr_q == ACC_OFS_CTRL1) ? rd_c1 :
        (addr_q == ACC_OFS_CTRL2) ? rd_c2 :
        (addr_q == ACC_OFS_RESH)  ? res_hi :
        (addr_q == ACC_OFS_RESL)  ? res_lo :
        (addr_q == ACC_OFS_IRQ)   ? rd_irq :
        (addr_q == ACC_OFS_STAT)  ? rd_st : ACC_RST_BYTE;
   assign hrdata_out = rd_q ? {24'h000000, rd_sel} : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////
   // Analog side selection
   logic [16:0] ch_oh;
   always_comb begin
      ch_oh = 17'h00000;
      if (chs_q < ACC_CH_PINS) begin
         ch_oh[chs_q[3:0]] = 1'b1;
      end else if (chs_q == ACC_CH_FIX2) begin
         ch_oh[14] = 1'b1;
      end else if (chs_q == ACC_CH_TEMP) begin
         ch_oh[15] = 1'b1;
      end else if (chs_q == ACC_CH_FIX1) begin
         ch_oh[16] = 1'b1;
      end
   end

   assign analog_out.chan_onehot = ch_oh;
   assign analog_out.ref_onehot  = {pref_q == ACC_REF_FIX, pref_q == ACC_REF_PIN,
                                    pref_q == ACC_REF_VDD};
   assign analog_out.powered     = on_q && !pwr_dn_q;
   assign analog_out.sample      = on_q && !conv;
   assign trial_out              = sar_q | trial;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_go_clears_end: assert property (@(posedge clk_in) disable iff (rst_in)
      last |=> !go_q && flag_q) else $error("completion left go set or flag clear");
   a_flag_set_wins: assert property (@(posedge clk_in) disable iff (rst_in)
      last && flag_clr |=> flag_q) else $error("done flag lost");
   a_no_start_off: assert property (@(posedge clk_in) disable iff (rst_in)
      !on_q && st_q == ACC_IDLE |=> st_q == ACC_IDLE) else $error("started while off");
   a_rc_start_delay: assert property (@(posedge clk_in) disable iff (rst_in)
      start && rc_sel |=> st_q == ACC_DELAY) else $error("rc start not delayed");
   a_just_right: assert property (@(posedge clk_in) disable iff (rst_in)
      fm_q |-> res_hi[7:2] == 6'h00) else $error("right justify upper bits");
   a_just_left: assert property (@(posedge clk_in) disable iff (rst_in)
      !fm_q |-> res_lo[5:0] == 6'h00 && res_hi == res_q[9:2]) else $error("left justify");
   a_sleep_abort: assert property (@(posedge clk_in) disable iff (rst_in)
      sleep_ab |=> st_q == ACC_IDLE && pwr_dn_q && on_q) else $error("sleep abort");
   a_sw_go_start: assert property (@(posedge clk_in) disable iff (rst_in)
      start && !rc_sel |=> st_q == ACC_CONV && go_q) else $error("go did not start");
   a_trig_sets_go: assert property (@(posedge clk_in) disable iff (rst_in)
      trg_hit && on_q && !pwr_dn_q && !conv |=> go_q) else $error("trigger ignored");
   a_ref_onehot: assert property (@(posedge clk_in) disable iff (rst_in)
      $onehot0(analog_out.ref_onehot) && (pref_q != 2'h1 || analog_out.ref_onehot == 3'h0))
      else $error("reference decode");
   a_chan_decode: assert property (@(posedge clk_in) disable iff (rst_in)
      chs_q == ACC_CH_TEMP |-> ch_oh == 17'h08000) else $error("channel decode");
   a_sleep_done_off: assert property (@(posedge clk_in) disable iff (rst_in)
      last && asleep && !ie_q |=> pwr_dn_q) else $error("no power down");
   a_wake_irq: assert property (@(posedge clk_in) disable iff (rst_in)
      asleep && flag_q && ie_q |=> wake_out) else $error("no wake");
   a_vec_global: assert property (@(posedge clk_in) disable iff (rst_in)
      !ge_q |=> !vector_out) else $error("vector without global");
   a_reset_clears: assert property (@(posedge clk_in)
      rst_in |=> !on_q && st_q == ACC_IDLE && !go_q) else $error("reset state");
   a_conv_length: assert property (@(posedge clk_in) disable iff (rst_in)
      last |-> step_q == 5'h16 && &bit_q) else $error("conversion length");
   a_clock_code: assert property (@(posedge clk_in) disable iff (rst_in)
      cs_q == 3'b110 |-> half_cyc == 8'h20) else $error("clock decode");
   a_partial_load: assert property (@(posedge clk_in) disable iff (rst_in)
      sw_ab && !last |=> res_q == $past(part)) else $error("partial result");

endmodule
`default_nettype wire

// File: acc_pkg.sv
// Package for the converter control block: offsets, fields, codes, timing
//
// Notes on behaviour
// - Channel field routes one of seventeen inputs; code decodes only fifteen, lines 12 and 13 never selected
// - Five-bit channel codes, unlisted codes connect none
// - Software picks positive reference source
// - Reference codes: 00 supply, 10 pin, 11 fixed
// - Clock codes pick divider or internal RC
// - Conversion lasts eleven and half bit periods
// - Done flag set on every conversion end; code sets it on completion only, never on abort
// - Enabled completion interrupt wakes sleeping processor
// - Wake resumes inline unless global enable set; code vectors only when peripheral enable is also set
// - Result justified per format bit
// - Unused six result bits read zero
// - Go bit starts conversion when module enabled
// - Completion clears go, sets flag, loads result
// - Abort loads partial result, fills with last bit
// - Reset clears registers and ends conversion
// - Internal RC start delayed one instruction cycle
// - Sleep completion without interrupt powers module down
// - Sleep without RC clock aborts and powers down
// - Rising trigger edge sets go bit
// - Four-bit trigger codes, higher codes reserved
package acc_pkg;
   // Register byte offsets
   localparam logic [7:0] ACC_OFS_CTRL0 = 8'h00;
   localparam logic [7:0] ACC_OFS_CTRL1 = 8'h04;
   localparam logic [7:0] ACC_OFS_CTRL2 = 8'h08;
   localparam logic [7:0] ACC_OFS_RESH  = 8'h0C;
   localparam logic [7:0] ACC_OFS_RESL  = 8'h10;
   localparam logic [7:0] ACC_OFS_IRQ   = 8'h14;
   localparam logic [7:0] ACC_OFS_STAT  = 8'h18;
   // Field positions
   localparam int ACC_C0_ON   = 0;
   localparam int ACC_C0_GO   = 1;
   localparam int ACC_C0_CHS  = 2;
   localparam int ACC_C1_PREF = 0;
   localparam int ACC_C1_CS   = 4;
   localparam int ACC_C1_FM   = 7;
   localparam int ACC_C2_TRIG = 4;
   localparam int ACC_IRQ_FLG = 0;
   localparam int ACC_IRQ_IE  = 1;
   localparam int ACC_IRQ_PE  = 2;
   localparam int ACC_IRQ_GE  = 3;
   // Reset values
   localparam logic [7:0] ACC_RST_BYTE = 8'h00;
   // Channel codes
   localparam logic [4:0] ACC_CH_FIX1 = 5'h1F;
   localparam logic [4:0] ACC_CH_TEMP = 5'h1D;
   localparam logic [4:0] ACC_CH_FIX2 = 5'h1C;
   localparam logic [4:0] ACC_CH_PINS = 5'h0C;
   // Reference codes
   localparam logic [1:0] ACC_REF_VDD = 2'h0;
   localparam logic [1:0] ACC_REF_PIN = 2'h2;
   localparam logic [1:0] ACC_REF_FIX = 2'h3;
   // Trigger codes
   localparam logic [3:0] ACC_TRG_MAX = 4'h5;
   // Conversion length in half bit periods (11.5 periods)
   localparam logic [4:0] ACC_HALF_STEPS = 5'h17;
   // Internal RC half period and instruction cycle, nanoseconds
   localparam int ACC_RC_HALF_NS = 1000;
   localparam int ACC_INSTR_NS   = 200;
   localparam int ACC_CLK_NS     = 50;
   localparam logic [7:0] ACC_RC_HALF_CYC = 8'(ACC_RC_HALF_NS / ACC_CLK_NS);
   localparam logic [7:0] ACC_INSTR_CYC   = 8'((ACC_INSTR_NS + ACC_CLK_NS - 1) / ACC_CLK_NS);

   typedef enum logic [1:0] {
      ACC_IDLE  = 2'b00,
      ACC_DELAY = 2'b01,
      ACC_CONV  = 2'b11
   } acc_state_t;

   // Analog-side selection bundle
   typedef struct packed {
      logic [16:0] chan_onehot;
      logic [2:0]  ref_onehot;
      logic        powered;
      logic        sample;
   } acc_analog_t;
endpackage

// File: tb_top.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import acc_pkg::*;
;
   // Bus, trigger and analog side stimulus and observation
   logic        clk_in;
   logic        rst_in;
   logic        hsel_in;
   logic [31:0] haddr_in;
   logic [1:0]  htrans_in;
   logic        hwrite_in;
   logic [2:0]  hsize_in;
   logic [31:0] hwdata_in;
   logic [31:0] hrdata_out;
   logic        hready_out;
   logic        hresp_out;
   logic [4:0]  trig_in;
   logic        sleep_in;
   logic        comp_in;
   acc_analog_t analog_out;
   logic [9:0]  trial_out;
   logic        wake_out;
   logic        vector_out;
   int          failures = 0;
   int          compares = 0;
   int          cyc = 0;

   // Zero-wait slave drives its own hready back in
   acc_ctrl #(.RES_W(10)) dut (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .hsel_in       (hsel_in),
      .haddr_in      (haddr_in),
      .htrans_in     (htrans_in),
      .hwrite_in     (hwrite_in),
      .hsize_in      (hsize_in),
      .hwdata_in     (hwdata_in),
      .hready_in     (hready_out),
      .hrdata_out    (hrdata_out),
      .hreadyout_out (hready_out),
      .hresp_out     (hresp_out),
      .trig_src_in   (trig_in),
      .sleep_in      (sleep_in),
      .comp_in       (comp_in),
      .analog_out    (analog_out),
      .trial_out     (trial_out),
      .wake_out      (wake_out),
      .vector_out    (vector_out)
   );

   // 20 MHz clock and a cycle count for timing conversions
   always #25 clk_in = ~clk_in;
   always @(posedge clk_in) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////
   // Compare, bus and stimulus helpers
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // Waits for hready; only the watchdog ends a stuck wait
   task automatic wait_rdy();
      @(posedge clk_in);
      while (hready_out !== 1'b1) begin
         @(posedge clk_in);
      end
   endtask

   task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
      haddr_in  <= {24'h00, a};
      htrans_in <= 2'h2;
      hwrite_in <= wr;
      wait_rdy();
      htrans_in <= 2'h0;
      hwdata_in <= wd;
      wait_rdy();
      rd = hrdata_out;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(a, 1'b1, d, x);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      xfer(a, 1'b0, 32'h00000000, x);
      chk(name, exp, x);
   endtask

   // Enable first, then go, then poll go until it drops
   task automatic conv(input logic [2:0] cs, input logic fm, output int n);
      logic [31:0] x;
      int t0;
      wr(ACC_OFS_CTRL1, {24'h00, fm, cs, 4'h0});
      wr(ACC_OFS_CTRL0, 32'h00000001);
      idle(4);
      wr(ACC_OFS_CTRL0, 32'h00000003);
      t0 = cyc;
      x = 32'h00000002;
      while (x[1] !== 1'b0 && cyc - t0 < 2000)
         xfer(ACC_OFS_CTRL0, 1'b0, 32'h00000000, x);
      n = cyc - t0;
   endtask

   // Trigger pulse long enough to pass the input synchroniser
   task automatic pulse(input logic [4:0] m);
      trig_in <= m;
      idle(4);
      trig_in <= 5'h00;
      idle(40);
   endtask

   function automatic logic [31:0] res_hi(input logic [9:0] r, input logic fm);
      return fm ? {30'h0, r[9:8]} : {24'h00, r[9:2]};
   endfunction

   function automatic logic [31:0] res_lo(input logic [9:0] r, input logic fm);
      return fm ? {24'h00, r[7:0]} : {24'h00, r[1:0], 6'h00};
   endfunction

   task automatic end_test(input string name);
      $display("test %s done, failures so far %0d", name, failures);
   endtask

   task automatic stop_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int n;
      int hp[8];
      logic [9:0] r;
      logic [4:0] own;
      logic [4:0] ch_code[7];
      logic [16:0] ch_exp[7];
      logic [2:0] ref_exp[4];
      hp = '{1, 4, 16, int'(ACC_RC_HALF_CYC), 2, 8, 32, int'(ACC_RC_HALF_CYC)};
      ch_code = '{5'h1F, 5'h1D, 5'h1C, 5'h00, 5'h0B, 5'h0C, 5'h1E};
      ch_exp = '{17'h10000, 17'h08000, 17'h04000, 17'h00001, 17'h00800, 17'h00000, 17'h00000};
      ref_exp = '{3'h1, 3'h0, 3'h2, 3'h4};
      clk_in = 1'b0;
      rst_in = 1'b1;
      hsel_in = 1'b1;
      haddr_in = 32'h00000000;
      htrans_in = 2'h0;
      hwrite_in = 1'b0;
      hsize_in = 3'h2;
      hwdata_in = 32'h00000000;
      trig_in = 5'h00;
      sleep_in = 1'b0;
      comp_in = 1'b0;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      for (int a = 0; a < 32; a += 4) rd_chk("reset_value", 8'(a), 32'h00000000);
      wr(8'h1C, 32'hFFFFFFFF);
      wr(ACC_OFS_RESH, 32'hFFFFFFFF);
      rd_chk("unmapped", 8'h1C, 32'h00000000);
      rd_chk("result_ro", ACC_OFS_RESH, 32'h00000000);
      chk("hresp", 32'h00000000, {31'h0, hresp_out});
      end_test("reset");
      for (int j = 0; j < 7; j++) begin
         wr(ACC_OFS_CTRL0, {25'h0, ch_code[j], 2'h1});
         rd_chk("ctrl0_rw", ACC_OFS_CTRL0, {25'h0, ch_code[j], 2'h1});
         chk("chan_sel", {15'h0, ch_exp[j]}, {15'h0, analog_out.chan_onehot});
      end
      // Reserved reference code 01 must select nothing
      for (int j = 0; j < 4; j++) begin
         wr(ACC_OFS_CTRL1, 32'(j));
         idle(1);
         chk("ref_sel", {29'h0, ref_exp[j]}, {29'h0, analog_out.ref_onehot});
      end
      end_test("select");
      // Every clock code, both formats, both result extremes
      for (int i = 0; i < 8; i++) begin
         comp_in <= i[2];
         r = i[2] ? 10'h3FF : 10'h000;
         wr(ACC_OFS_IRQ, 32'h00000000);
         conv(3'(i), i[0], n);
         chk("conv_len", 32'h1, 32'(n >= 23 * hp[i] - 2 && n <= 23 * hp[i] + 12 + (i % 4 == 3 ? 4 : 0)));
         rd_chk("done_flag", ACC_OFS_IRQ, 32'h00000001);
         rd_chk("res_high", ACC_OFS_RESH, res_hi(r, i[0]));
         rd_chk("res_low", ACC_OFS_RESL, res_lo(r, i[0]));
      end
      end_test("convert");
      wr(ACC_OFS_CTRL0, 32'h00000000);
      wr(ACC_OFS_CTRL0, 32'h00000002);
      idle(40);
      rd_chk("go_disabled", ACC_OFS_CTRL0, 32'h00000000);
      rd_chk("res_hold", ACC_OFS_RESL, 32'h000000FF);
      rd_chk("flag_hold", ACC_OFS_IRQ, 32'h00000001);
      // Zero result first, so the aborted load is visible
      comp_in <= 1'b0;
      conv(3'h0, 1'b1, n);
      comp_in <= 1'b1;
      wr(ACC_OFS_CTRL1, 32'h000000E0);
      wr(ACC_OFS_CTRL0, 32'h00000003);
      rd_chk("state_conv", ACC_OFS_STAT, 32'h00000003);
      chk("sampling", 32'h00000000, {31'h0, analog_out.sample});
      chk("trial_msb", 32'h00000200, {22'h0, trial_out});
      idle(400);
      wr(ACC_OFS_CTRL0, 32'h00000001);
      idle(2);
      rd_chk("abort_go", ACC_OFS_CTRL0, 32'h00000001);
      rd_chk("abort_high", ACC_OFS_RESH, 32'h00000003);
      rd_chk("abort_low", ACC_OFS_RESL, 32'h000000FF);
      end_test("abort");
      // Other sources must not start; the selected one must
      wr(ACC_OFS_CTRL1, 32'h00000080);
      for (int k = 0; k < 7; k++) begin
         own = (k > 0 && k < 6) ? 5'(1 << (k - 1)) : 5'h00;
         wr(ACC_OFS_CTRL2, 32'(k << 4));
         wr(ACC_OFS_IRQ, 32'h00000000);
         pulse(~own);
         rd_chk("trig_other", ACC_OFS_IRQ, 32'h00000000);
         pulse(own);
         rd_chk("trig_own", ACC_OFS_IRQ, 32'(own != 5'h00));
      end
      end_test("trigger");
      wr(ACC_OFS_IRQ, 32'h00000000);
      wr(ACC_OFS_CTRL1, 32'h00000060);
      wr(ACC_OFS_CTRL0, 32'h00000003);
      idle(100);
      sleep_in <= 1'b1;
      idle(10);
      rd_chk("sleep_abort", ACC_OFS_CTRL0, 32'h00000001);
      rd_chk("sleep_off", ACC_OFS_STAT, 32'h00000004);
      sleep_in <= 1'b0;
      idle(10);
      // Internal RC conversion in sleep, interrupt off then on
      for (int w = 0; w < 2; w++) begin
         wr(ACC_OFS_IRQ, w ? 32'h00000006 : 32'h00000000);
         wr(ACC_OFS_CTRL1, 32'h00000030);
         wr(ACC_OFS_CTRL0, 32'h00000003);
         sleep_in <= 1'b1;
         idle(23 * int'(ACC_RC_HALF_CYC) + 40);
         chk("wake", 32'(w), {31'h0, wake_out});
         chk("vector_off", 32'h00000000, {31'h0, vector_out});
         chk("powered", 32'(w), {31'h0, analog_out.powered});
         rd_chk("sleep_flag", ACC_OFS_IRQ, w ? 32'h00000007 : 32'h00000001);
         rd_chk("sleep_ctrl", ACC_OFS_CTRL0, 32'h00000001);
         if (w == 0) rd_chk("sleep_pdn", ACC_OFS_STAT, 32'h00000004);
         wr(ACC_OFS_IRQ, 32'h0000000F);
         idle(2);
         chk("vector_on", 32'h00000001, {31'h0, vector_out});
         sleep_in <= 1'b0;
         wr(ACC_OFS_IRQ, 32'h00000000);
      end
      end_test("sleep");
      wr(ACC_OFS_CTRL1, 32'h00000060);
      wr(ACC_OFS_CTRL0, 32'h0000007F);
      idle(50);
      rst_in <= 1'b1;
      idle(2);
      rst_in <= 1'b0;
      rd_chk("rst_ctrl0", ACC_OFS_CTRL0, 32'h00000000);
      rd_chk("rst_stat", ACC_OFS_STAT, 32'h00000000);
      rd_chk("rst_res", ACC_OFS_RESL, 32'h00000000);
      end_test("midreset");
      stop_test();
   end

   ////////////////////////////////////////////////////////////
   // Watchdog well past the expected run of some 5000 cycles
   initial begin
      repeat (30000) @(posedge clk_in);
      failures++;
      $display("[FAIL] watchdog expected finish seen timeout");
      stop_test();
   end
endmodule
`default_nettype wire
